// *** design/sw_ctrl_pkg.sv ***
// constants for the switch control serial/parallel port
package sw_ctrl_pkg;
  localparam int          WORD_W        = 16;
  localparam int          REG_W         = 8;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  WORD_BITS     = 5'h10;
  localparam int          WE_BIT        = 15;
  localparam int          CTL_MSB       = 15;
  localparam int          CTL_LSB       = 8;
  localparam int          ST_MSB        = 7;
  localparam int          ST_LSB        = 0;
  localparam int          HV_MSB        = 3;
  localparam int          FAULT_BIT     = 6;
  localparam int          SLEEP_BIT     = 5;
  localparam int          FSD_BIT       = 4;
  localparam int          HVMON_BIT     = 3;
  localparam int          PUMP_BIT      = 1;
  localparam logic [7:0]  STATE_RST     = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] SHIFT_RST     = 16'h0000;
  localparam logic [3:0]  HV_OFF        = 4'h0;
  localparam int          SCK_MAX_MHZ   = 33;
endpackage

// *** design/switch_control_serial_parallel_port.sv ***
// serial/parallel control port of a loopback switch driver
`timescale 1ns/1ps
// Functional notes
// - mode select low uses serial port, high uses parallel pins.
// - chip select falling presents image word msb on data out.
// - data in sampled on serial clock rising edge; clock idle unselected.
// - next bit shifted out on each serial clock falling edge.
// - 16-bit shift register; old word leaves while new enters.
// - chip select rising loads registers only when write enable is one.
// - word is write enable, 7 control bits, 8 state bits, msb first.
// - write enable zero is a read; host captures data out.
// - state bits 3..0 drive outputs d..a; host writes 7..4 zero.
// - reset clears state and control registers.
// - serial mode ignores pump and fault-mode pins, uses control bits.
// - fault flag sets on fault, holds until host writes zero.
// - control bit 5 puts analog circuits to sleep.
// - control bit 4 disables fault shutdown when one.
// - control bit 3 turns off pump under-voltage monitor.
// - control bit 1 enables charge pump; bits 2 and 0 unused.
// - parallel mode needs mode select one and orientation strap zero.
// - parallel controls 1..4 drive outputs a..d directly.
// - fault with shutdown enabled opens switches and stops pump.
module switch_control_serial_parallel_port
  import sw_ctrl_pkg::*;
(
  input  wire logic ref_clk_i,             // system clock
  input  wire logic nrst_i,                // async reset, active low
  input  wire logic mode_select_i,         // 0 serial, 1 parallel
  input  wire logic orientation_strap_i,   // must be 0 for parallel mode
  input  wire logic sck_i,                 // serial clock (link clock)
  input  wire logic chip_select_low_i,     // frame select, active low
  input  wire logic sdi_i,                 // serial data in
  output logic      sdo_o,                 // serial data out
  input  wire logic parallel_control_1_i,  // parallel drive a
  input  wire logic parallel_control_2_i,  // parallel drive b
  input  wire logic parallel_control_3_i,  // parallel drive c
  input  wire logic parallel_control_4_i,  // parallel drive d
  input  wire logic pump_enable_pin_i,     // parallel-mode pump enable
  input  wire logic fault_shutdown_select_i, // parallel-mode shutdown off
  input  wire logic supply_fault_i,        // from fault comparators
  output logic      high_voltage_out_a_o,  // switch driver a
  output logic      high_voltage_out_b_o,  // switch driver b
  output logic      high_voltage_out_c_o,  // switch driver c
  output logic      high_voltage_out_d_o,  // switch driver d
  output logic      pump_enable_o,         // charge pump on
  output logic      sleep_o,               // analog circuits off
  output logic      hv_monitor_enable_o,   // pump under-voltage monitor on
  output logic      fault_flag_o           // latched fault status
);

  // link domain, clocked by sck and cleared by chip select high
  // frame walk: select falls and the image msb shows at once; every
  // rising sck takes one input bit, every falling sck moves the next
  // output bit out; after one word the received bits follow on the
  // output, which lets several devices share one frame in a chain
  // hazard: the image is read from core-domain registers; the host
  // leaves the port idle a few core cycles after a write, or a read
  // could show a mix of old and new fields

  // shifter, output flop and bit count
  logic [WORD_W-1:0] shift_reg;
  logic              sdo_bit;
  logic [CNT_W-1:0]  bit_cnt;

  // frame capture, handed to the core by a toggle
  logic              frame_toggle;
  logic [WORD_W-1:0] rx_word;

  // registers and the word a read shows
  logic [REG_W-1:0]  switch_drive_state;
  logic [REG_W-1:0]  control_settings;
  logic [WORD_W-1:0] image_word;

  // word reloaded into the shifter at frame start
  assign image_word = {1'b0, control_settings[CTL_MSB-CTL_LSB-1:0],
                       switch_drive_state};

  // reset of the link side: async on chip select; the image enters the shifter
  // at the first rising sck edge; image is quasi-static while the frame runs
  // msb ready at select
  always_ff @(posedge sck_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      shift_reg <= SHIFT_RST;
    end else begin
      if (bit_cnt == '0) begin
        shift_reg <= {image_word[WORD_W-2:0], sdi_i};
      end else begin
        shift_reg <= {shift_reg[WORD_W-2:0], sdi_i};
      end
    end
  end

  // rising edges seen in this frame; saturates at one word, which is all
  // the output mux needs, so long daisy frames cannot wrap it
  always_ff @(posedge sck_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      bit_cnt <= '0;
    end else if (bit_cnt != WORD_BITS) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(negedge sck_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      sdo_bit <= 1'b0;
    end else begin
      sdo_bit <= shift_reg[WORD_W-1];
    end
  end

  // before first rise show image msb
  // after 16 bits the received word shifts onward for chaining
  always_comb begin
    if (bit_cnt == '0) begin
      sdo_o = image_word[WORD_W-1];
    end else begin
      sdo_o = sdo_bit;
    end
  end

  // capture the word on frame end; toggle tells the core a frame closed
  always_ff @(posedge chip_select_low_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_word      <= SHIFT_RST;
      frame_toggle <= 1'b0;
    end else begin
      rx_word      <= shift_reg;
      frame_toggle <= ~frame_toggle;
    end
  end

  // core domain, clocked by ref_clk; a closed frame arrives as a toggle,
  // the register load follows three flops later and the pins one more

  // crossing from the link side
  logic [2:0]        tog_sync;
  logic              frame_done;
  logic [WORD_W-1:0] word_hold;

  // pin synchronisers
  logic [1:0]        mode_sync;
  logic [1:0]        strap_sync;
  logic [1:0]        fault_sync;
  logic [3:0]        par_raw;
  logic [3:0]        par_sync0;
  logic [3:0]        par_sync1;
  logic [1:0]        pump_pin_sync;
  logic [1:0]        fsel_sync;

  // shutdown and mode decode
  logic              pump_latched_off;
  logic              pump_req_d;
  logic              serial_mode;
  logic              parallel_mode;
  logic              pump_req;
  logic              shutdown_en;
  logic              write_frame;

  // driver flops
  logic [3:0]        hv_drive;

  // event crossing: the toggle runs through three flops and its edge
  // gives one pulse per closed frame
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_sync <= '0;
    end else begin
      tog_sync <= {tog_sync[1:0], frame_toggle};
    end
  end

  // rx_word settles at select rise, long before the toggle has passed
  // the synchroniser, so the copy used at the pulse is clean
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_hold <= SHIFT_RST;
    end else begin
      word_hold <= rx_word;
    end
  end
  assign frame_done = tog_sync[2] ^ tog_sync[1];

  // two-flop synchronisers for the level pins; none of them is related
  // to ref_clk, so nothing reads the first flop
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_sync     <= '0;
      strap_sync    <= '0;
      fault_sync    <= '0;
      pump_pin_sync <= '0;
      fsel_sync     <= '0;
    end else begin
      mode_sync     <= {mode_sync[0], mode_select_i};
      strap_sync    <= {strap_sync[0], orientation_strap_i};
      fault_sync    <= {fault_sync[0], supply_fault_i};
      pump_pin_sync <= {pump_pin_sync[0], pump_enable_pin_i};
      fsel_sync     <= {fsel_sync[0], fault_shutdown_select_i};
    end
  end

  // the four drive pins, one identical two-flop pair per pin
  // limitation: pins settle one by one, so a code change may show a
  // mixed code for a cycle; the host holds codes as levels
  assign par_raw = {parallel_control_4_i, parallel_control_3_i,
                    parallel_control_2_i, parallel_control_1_i};
  for (genvar g = 0; g <= HV_MSB; g++) begin : g_par_sync
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        par_sync0[g] <= 1'b0;
        par_sync1[g] <= 1'b0;
      end else begin
        par_sync0[g] <= par_raw[g];
        par_sync1[g] <= par_sync0[g];
      end
    end
  end

  assign serial_mode   = ~mode_sync[1];
  // parallel needs strap low
  // mode high with the strap high is neither mode: drivers stay open
  assign parallel_mode = mode_sync[1] & ~strap_sync[1];

  // write only with write enable
  // parallel mode drops serial writes, though reads still shift out
  assign write_frame   = frame_done & serial_mode & word_hold[WE_BIT];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      switch_drive_state <= STATE_RST;
    end else if (write_frame) begin
      switch_drive_state <= word_hold[ST_MSB:ST_LSB];
    end
  end

  // fault set wins over host clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      control_settings <= CTRL_RST;
    end else begin
      if (write_frame) begin
        control_settings <= word_hold[CTL_MSB:CTL_LSB];
      end
      if (fault_sync[1]) begin
        control_settings[FAULT_BIT] <= 1'b1;
      end
    end
  end

  // pins only count with mode select high, strap high included
  always_comb begin
    if (serial_mode) begin
      pump_req    = control_settings[PUMP_BIT];
      shutdown_en = ~control_settings[FSD_BIT];
    end else begin
      pump_req    = pump_pin_sync[1];
      shutdown_en = ~fsel_sync[1];
    end
  end

  // previous pump request, for the restart edge
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_req_d <= 1'b0;
    end else begin
      pump_req_d <= pump_req;
    end
  end

  // fault shutdown latch, released by a pump enable rise
  // restart needs request low then high
  // a fault still present keeps the latch set: restart waits for it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_latched_off <= 1'b0;
    end else begin
      if (fault_sync[1] && shutdown_en) begin
        pump_latched_off <= 1'b1;
      end else if (pump_req && !pump_req_d) begin
        pump_latched_off <= 1'b0;
      end
    end
  end

  // one place decides what the four drivers show; shutdown wins over
  // both modes, and a mode select with the strap high drives nothing
  function automatic logic [3:0] pick_drive(
    input logic       latched_off,
    input logic       par_mode,
    input logic       ser_mode,
    input logic [3:0] par_pins,
    input logic [3:0] state_bits
  );
    logic [3:0] pick;
    pick = HV_OFF;
    if (latched_off) begin
      pick = HV_OFF;
    end else if (par_mode) begin
      pick = par_pins;
    end else if (ser_mode) begin
      pick = state_bits;
    end
    return pick;
  endfunction

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hv_drive <= HV_OFF;
    end else begin
      hv_drive <= pick_drive(pump_latched_off, parallel_mode, serial_mode,
                             par_sync1, switch_drive_state[HV_MSB:ST_LSB]);
    end
  end

  // drivers straight from the flop, so the switch lines never glitch
  assign {high_voltage_out_d_o, high_voltage_out_c_o,
          high_voltage_out_b_o, high_voltage_out_a_o} = hv_drive;

  // the latch keeps the pump off
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_enable_o <= 1'b0;
    end else begin
      pump_enable_o <= pump_req & ~pump_latched_off;
    end
  end

  // sleep only from serial control
  // parallel mode has no sleep pin, so sleep stays off there
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_o <= 1'b0;
    end else begin
      sleep_o <= serial_mode & control_settings[SLEEP_BIT];
    end
  end

  // monitor off bit in serial mode
  // parallel mode: the monitor follows the pump pin
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hv_monitor_enable_o <= 1'b0;
    end else begin
      hv_monitor_enable_o <= serial_mode ? ~control_settings[HVMON_BIT]
                                         : pump_pin_sync[1];
    end
  end

  // flag output mirrors the latched bit
  // one cycle behind the register, like every other ref_clk output
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_flag_o <= 1'b0;
    end else begin
      fault_flag_o <= control_settings[FAULT_BIT];
    end
  end

endmodule

// *** dv/sw_ctrl_monitor.sv ***
// concurrent checks on the switch control port pins
`timescale 1ns/1ps
module sw_ctrl_monitor (
  input wire logic ref_clk_i,                          // core clock
  input wire logic nrst_i,                             // reset, active low
  input wire logic mode_select_i,                      // mode pin
  input wire logic orientation_strap_i,                // strap pin
  input wire logic chip_select_low_i,                  // frame select
  input wire logic parallel_control_1_i,               // drive a pin
  input wire logic parallel_control_2_i,               // drive b pin
  input wire logic parallel_control_3_i,               // drive c pin
  input wire logic parallel_control_4_i,               // drive d pin
  input wire logic pump_enable_pin_i,                  // pump pin
  input wire logic fault_shutdown_select_i,            // shutdown off pin
  input wire logic supply_fault_i,                     // fault level
  input wire logic high_voltage_out_a_o,               // driver a
  input wire logic high_voltage_out_b_o,               // driver b
  input wire logic high_voltage_out_c_o,               // driver c
  input wire logic high_voltage_out_d_o,               // driver d
  input wire logic pump_enable_o,                      // pump on
  input wire logic sleep_o,                            // sleep
  input wire logic hv_monitor_enable_o,                // monitor on
  input wire logic fault_flag_o                        // fault flag
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // packed views; mode pins pass two sync flops, hence the run lengths
  wire logic [3:0] hv = {high_voltage_out_d_o, high_voltage_out_c_o,
                         high_voltage_out_b_o, high_voltage_out_a_o};
  wire logic [3:0] ctl = {parallel_control_4_i, parallel_control_3_i,
                          parallel_control_2_i, parallel_control_1_i};
  wire logic       par = mode_select_i && !orientation_strap_i;
  a_reset_clears: assert property ($rose(nrst_i) |-> hv == 4'h0 &&
    !pump_enable_o && !sleep_o && !fault_flag_o) else $error("reset");
  a_parallel_follow: assert property ((par && fault_shutdown_select_i &&
    pump_enable_pin_i && pump_enable_o && $stable(ctl))[*5] |-> hv == ctl)
    else $error("parallel drive");
  a_strap_blocks: assert property ((mode_select_i &&
    orientation_strap_i)[*5] |-> hv == 4'h0) else $error("strap");
  a_pump_pin_off: assert property ((par && !pump_enable_pin_i)[*5]
    |-> !pump_enable_o && !hv_monitor_enable_o) else $error("pump pin");
  a_flag_sets: assert property (supply_fault_i[*4] |=> fault_flag_o)
    else $error("fault flag");
  a_fault_opens: assert property ((par && !fault_shutdown_select_i &&
    supply_fault_i)[*4] |=> hv == 4'h0 && !pump_enable_o)
    else $error("shutdown");
  a_flag_holds: assert property ((chip_select_low_i &&
    fault_flag_o)[*8] |=> fault_flag_o) else $error("flag hold");
  a_hold_unselected: assert property ((!mode_select_i &&
    chip_select_low_i && !supply_fault_i)[*8] |=> $stable(hv) &&
    $stable(pump_enable_o)) else $error("unselected change");
endmodule
bind switch_control_serial_parallel_port sw_ctrl_monitor i_mon (.*);

// *** dv/host_spi_model.sv ***
// host model driving the serial link
`timescale 1ns/1ps
module host_spi_model (
  input  wire logic sdo_i,              // device serial out
  output logic      sck_o,              // link clock, still outside frames
  output logic      chip_select_low_o,  // frame select, active low
  output logic      sdi_o               // device serial in
);
  // idle levels: clock still, data at its pull-down
  initial begin
    sck_o = 1'b0;
    chip_select_low_o = 1'b1;
    sdi_o = 1'b0;
  end
  // frame of n bits, msb first, 15 ns clock
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [31:0] rd);
    rd = 32'h0;
    chip_select_low_o = 1'b0;
    #8;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #7.5 sck_o = 1'b1;
      rd[i] = sdo_i;
      #7.5 sck_o = 1'b0;
    end
    #8 chip_select_low_o = 1'b1;
    sdi_o = 1'b0;
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the switch control port
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_i = 1'b0, nrst_i = 1'b0, mode_select_i = 1'b0;
  logic        strap = 1'b0, flt_sel = 1'b0, fault = 1'b0, pin = 1'b0;
  logic [3:0]  ctl = 4'h0;
  logic [31:0] rd;
  wire logic   sck_i, chip_select_low_i, sdi_i, sdo_o, a, b, c, d;
  wire logic   pump, slp, mon, flag;
  wire [15:0]  outs = {8'h00, flag, slp, mon, pump, d, c, b, a};
  int          fail_count = 0;
  int          total_checks = 0;
  // clock and hang guard
  initial forever #25 ref_clk_i = ~ref_clk_i;
  initial begin
    #2000000 fail_count++;
    test_done;
  end
  switch_control_serial_parallel_port i_dut (.ref_clk_i, .nrst_i,
    .mode_select_i, .orientation_strap_i(strap), .sck_i,
    .chip_select_low_i, .sdi_i, .sdo_o, .parallel_control_1_i(ctl[0]),
    .parallel_control_2_i(ctl[1]), .parallel_control_3_i(ctl[2]),
    .parallel_control_4_i(ctl[3]), .pump_enable_pin_i(pin),
    .fault_shutdown_select_i(flt_sel), .supply_fault_i(fault),
    .high_voltage_out_a_o(a), .high_voltage_out_b_o(b),
    .high_voltage_out_c_o(c), .high_voltage_out_d_o(d),
    .pump_enable_o(pump), .sleep_o(slp), .hv_monitor_enable_o(mon),
    .fault_flag_o(flag));
  host_spi_model i_host (.sdo_i(sdo_o), .sck_o(sck_i),
    .chip_select_low_o(chip_select_low_i), .sdi_o(sdi_i));
  task automatic chk(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // one frame, then room for the load and the output update
  task automatic xfer(input logic [31:0] w, input int n);
    @(negedge ref_clk_i);
    i_host.frame(w, n, rd);
    tick(6);
  endtask
  task automatic t_write_read;
    xfer(32'h8A05, 16);
    chk("outputs", 16'h0015, outs);
    xfer(32'h0F0F, 16);
    chk("read image", 16'h0A05, rd[15:0]);
    chk("outputs", 16'h0015, outs);
    xfer(32'hA000, 16);
    chk("sleep", 16'h0040, outs & 16'h0040);
    $display("write and read done");
  endtask
  task automatic t_daisy;
    xfer(32'h7F00_8001, 32);
    chk("chain head", 16'h2000, rd[31:16]);
    chk("chain pass", 16'h7F00, rd[15:0]);
    chk("outputs", 16'h0021, outs);
    $display("daisy chain done");
  endtask
  task automatic t_fault;
    xfer(32'h8203, 16);
    fault = 1'b1;
    tick(6);
    fault = 1'b0;
    tick(2);
    chk("fault outputs", 16'h0080, outs & 16'h00DF);
    xfer(32'h0000, 16);
    chk("flag bit", 16'h4000, rd[15:0] & 16'h4000);
    xfer(32'h8003, 16);
    xfer(32'h8203, 16);
    chk("restart", 16'h0033, outs);
    $display("fault done");
  endtask
  task automatic t_parallel;
    logic [3:0] codes [8] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'hC,
                              4'hF};
    mode_select_i = 1'b1;
    flt_sel = 1'b1;
    pin = 1'b1;
    foreach (codes[i]) begin
      ctl = codes[i];
      tick(6);
      chk("drivers", {12'h000, codes[i]}, outs & 16'h000F);
    end
    fault = 1'b1;
    tick(6);
    chk("no shutdown", 16'h000F, outs & 16'h000F);
    flt_sel = 1'b0;
    tick(6);
    chk("shutdown", 16'h0000, outs & 16'h001F);
    fault = 1'b0;
    pin = 1'b0;
    tick(6);
    chk("pump pin", 16'h0000, outs & 16'h0030);
    pin = 1'b1;
    tick(6);
    chk("pin restart", 16'h003F, outs & 16'h003F);
    strap = 1'b1;
    tick(6);
    chk("strap", 16'h0000, outs & 16'h000F);
    $display("parallel done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_reset;
    tick(15);
    chk("reset outputs", 16'h0000, outs);
    tick(1);
    nrst_i = 1'b1;
    tick(3);
    chk("after reset", 16'h0000, outs & 16'h00DF);
    xfer(32'h0000, 16);
    chk("reset image", 16'h0000, rd[15:0]);
    $display("reset done");
  endtask
  // main sequence
  initial begin
    t_reset();
    t_write_read();
    t_daisy();
    t_fault();
    t_parallel();
    test_done();
  end
endmodule
